// *** pkg/rsd_regs.svh ***
// Purpose: Offsets, field positions and reset values of the radio SERDES registers.
// Assumes: Six-bit register address carried in the serial command byte.
// Notes: Definitions only.
`ifndef RSD_REGS_SVH
`define RSD_REGS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define RSD_ADDR_RX_STAT 6'h08
`define RSD_ADDR_RX_BYTE_A 6'h09
`define RSD_ADDR_RX_VALID_A 6'h0a
`define RSD_ADDR_RX_BYTE_B 6'h0b
`define RSD_ADDR_RX_VALID_B 6'h0c
`define RSD_ADDR_TX_IRQ_EN 6'h0d
`define RSD_ADDR_TX_STAT 6'h0e
`define RSD_ADDR_TX_BYTE 6'h0f
`define RSD_ADDR_TX_VALID 6'h10
`define RSD_ADDR_CODE_LO 6'h11
`define RSD_ADDR_CODE_HI 6'h18
`define RSD_ADDR_ZERO_THR 6'h19

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RSD_RST_CODE 64'h1e8b6a3de0e9b222
`define RSD_RST_ZERO_THR 7'h08

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define RSD_TX_UNDER 3
`define RSD_TX_OVER 2
`define RSD_TX_DONE 1
`define RSD_TX_EMPTY 0
`define RSD_SPI_WR_BIT 7
`define RSD_SPI_INC_BIT 6

// ------------------------------------------------------------
// Sizes
// ------------------------------------------------------------
`define RSD_FIFO_WIDTH 16
`define RSD_FIFO_DEPTH 32
`define RSD_CHIP_LAST_LONG 6'h3f
`define RSD_CHIP_LAST_SHORT 6'h1f

`endif

// *** pkg/rsd_pkg.sv ***
// Purpose: Types shared by the radio SERDES register block.
// Assumes: Constants come from rsd_regs.svh.
// Notes: One state struct per module.
package rsd_pkg;

    // ------------------------------------------------------------
    // Serial port phases
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        RSD_SPI_IDLE = 3'b001,
        RSD_SPI_CMD = 3'b010,
        RSD_SPI_DATA = 3'b100
    } rsd_spi_e;

    // ------------------------------------------------------------
    // One receive channel
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] bits;
        logic [7:0] marks;
        logic [2:0] pos;
        logic begun;
        logic [3:0] gap;
        logic push;
        logic [15:0] push_word;
        logic [7:0] byte_q;
        logic [7:0] valid_q;
        logic holding;
        logic full;
        logic eof;
        logic flow;
    } rsd_rx_chan_s;

    // ------------------------------------------------------------
    // Whole block state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic sclk_d;
        rsd_spi_e spi;
        logic [2:0] bitcnt;
        logic [7:0] sh_in;
        logic [7:0] sh_out;
        logic wr;
        logic inc;
        logic [5:0] addr;
        logic miso_oe;
        logic [3:0] tx_irq_en;
        logic [7:0] tx_byte;
        logic [7:0] tx_mask;
        logic tx_pend;
        logic [7:0] sh_data;
        logic [7:0] sh_mask;
        logic tx_started;
        logic tx_done;
        logic tx_over;
        logic tx_under;
        logic tx_bit;
        logic tx_bit_is_data;
        logic irq;
        logic [63:0] code;
        logic [6:0] thr;
        logic [5:0] chip_idx;
        logic chip;
        rsd_rx_chan_s [1:0] ch;
    } rsd_state_s;

endpackage

// *** hdl/rsd_serdes_regs.sv ***
// Purpose: Byte-wide SERDES registers of a spread-spectrum baseband, reached over SPI.
// Assumes: Bit and chip strobes, enables and end-of-frame length come from same-clock logic.
// Notes: SPI pins are asynchronous and pass two flip-flops before use.
`timescale 1ns/100ps
`include "rsd_regs.svh"

// ------------------------------------------------------------
// Receive byte buffer
// ------------------------------------------------------------
module rsd_fifo #(
    parameter int WIDTH = `RSD_FIFO_WIDTH,
    parameter int DEPTH = `RSD_FIFO_DEPTH,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } rsd_fifo_s;

    rsd_fifo_s st;
    rsd_fifo_s next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign in_ready = (st.wp[AW] == st.rp[AW]) || (st.wp[AW-1:0] != st.rp[AW-1:0]);
    assign out_valid = st.wp != st.rp;
    assign out_data = mem[st.rp[AW-1:0]];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wp = st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = st.rp + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Storage carries no reset; pointers alone decide what is valid
    always_ff @(posedge clk) begin
        if (push) begin
            mem[st.wp[AW-1:0]] <= in_data;
        end
    end
endmodule

// ------------------------------------------------------------
// Register block
// ------------------------------------------------------------
module rsd_serdes_regs
    import rsd_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    input wire logic spi_ss_n,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic rx_enable,
    input wire logic tx_enable,
    input wire logic [2:0] eof_length,
    input wire logic bit_tick,
    input wire logic [1:0] rx_bit,
    input wire logic [1:0] rx_bit_ok,
    output logic tx_bit,
    output logic tx_bit_is_data,
    output logic tx_irq_req,
    input wire logic chip_tick,
    input wire logic code_short,
    input wire logic code_upper,
    output logic chip,
    output logic [63:0] spreading_code,
    output logic [6:0] zero_threshold
);
    rsd_state_s st;
    rsd_state_s next_st;
    logic [1:0] f_in_ready;
    logic [1:0] f_out_valid;
    logic [1:0] f_out_ready;
    logic [15:0] f_out_data [2];

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] rx_nibble(input rsd_rx_chan_s c);
        rx_nibble = {c.valid_q == 8'hff, c.flow, c.eof, c.full};
    endfunction

    function automatic logic [3:0] tx_flags(input rsd_state_s s);
        tx_flags = {s.tx_under, s.tx_over, s.tx_done, ~s.tx_pend};
    endfunction

    function automatic logic [7:0] reg_read(input rsd_state_s s, input logic [5:0] a,
                                            input logic rx_en, input logic tx_en);
        logic [2:0] k;
        k = 3'(a - `RSD_ADDR_CODE_LO);
        reg_read = 8'h00;
        case (a)
            `RSD_ADDR_RX_STAT: begin
                if (rx_en) begin
                    reg_read = {rx_nibble(s.ch[1]), rx_nibble(s.ch[0])};
                end
            end
            `RSD_ADDR_RX_BYTE_A: reg_read = s.ch[0].byte_q;
            `RSD_ADDR_RX_VALID_A: reg_read = s.ch[0].valid_q;
            `RSD_ADDR_RX_BYTE_B: reg_read = s.ch[1].byte_q;
            `RSD_ADDR_RX_VALID_B: reg_read = s.ch[1].valid_q;
            `RSD_ADDR_TX_IRQ_EN: reg_read = {4'h0, s.tx_irq_en};
            `RSD_ADDR_TX_STAT: begin
                if (tx_en) begin
                    reg_read = {4'h0, tx_flags(s)};
                end
            end
            `RSD_ADDR_TX_BYTE: reg_read = s.tx_byte;
            `RSD_ADDR_TX_VALID: reg_read = s.tx_mask;
            `RSD_ADDR_ZERO_THR: reg_read = {1'b0, s.thr};
            default: begin
                if (a >= `RSD_ADDR_CODE_LO && a <= `RSD_ADDR_CODE_HI) begin
                    reg_read = s.code[{k, 3'b000} +: 8];
                end
            end
        endcase
    endfunction

    // ------------------------------------------------------------
    // Receive buffers
    // ------------------------------------------------------------
    for (genvar c = 0; c < 2; c++) begin : g_fifo
        assign f_out_ready[c] = ~st.ch[c].holding;
        rsd_fifo #(
            .WIDTH(`RSD_FIFO_WIDTH),
            .DEPTH(`RSD_FIFO_DEPTH)
        ) u_fifo (
            .clk(clk),
            .sys_rst(sys_rst),
            .in_valid(st.ch[c].push),
            .in_ready(f_in_ready[c]),
            .in_data(st.ch[c].push_word),
            .out_valid(f_out_valid[c]),
            .out_ready(f_out_ready[c]),
            .out_data(f_out_data[c])
        );
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic rise;
        logic fall;
        logic [7:0] byte_in;
        logic [5:0] next_addr;
        logic rd_stb;
        logic wr_stb;
        logic [5:0] acc_addr;
        logic [2:0] k;
        logic move;
        logic eof_hit;
        logic [7:0] nb;
        logic [7:0] nm;
        logic [5:0] last;
        rise = 1'b0;
        fall = 1'b0;
        byte_in = 8'h00;
        next_addr = 6'h00;
        rd_stb = 1'b0;
        wr_stb = 1'b0;
        acc_addr = 6'h00;
        k = 3'h0;
        move = 1'b0;
        eof_hit = 1'b0;
        nb = 8'h00;
        nm = 8'h00;
        last = 6'h00;
        next_st = st;

        // Serial port: only the second stage is looked at
        next_st.sync1 = {spi_sclk, spi_mosi, spi_ss_n};
        next_st.sync2 = st.sync1;
        next_st.sclk_d = st.sync2[2];
        rise = st.sync2[2] & ~st.sclk_d;
        fall = ~st.sync2[2] & st.sclk_d;
        if (st.sync2[0]) begin
            next_st.spi = RSD_SPI_IDLE;
            next_st.bitcnt = 3'h0;
            next_st.miso_oe = 1'b0;
        end else begin
            next_st.miso_oe = 1'b1;
            if (st.spi == RSD_SPI_IDLE) begin
                next_st.spi = RSD_SPI_CMD;
            end
            if (rise) begin
                byte_in = {st.sh_in[6:0], st.sync2[1]};
                next_st.sh_in = byte_in;
                next_st.bitcnt = st.bitcnt + 3'h1;
                if (st.bitcnt == 3'h7) begin
                    if (st.spi == RSD_SPI_DATA) begin
                        wr_stb = st.wr;
                        acc_addr = st.addr;
                        next_addr = st.addr + {5'h00, st.inc};
                        // Prefetch only in bursts, so a plain read never pops a second byte
                        rd_stb = ~st.wr & st.inc;
                    end else begin
                        next_st.wr = byte_in[`RSD_SPI_WR_BIT];
                        next_st.inc = byte_in[`RSD_SPI_INC_BIT];
                        next_addr = byte_in[5:0];
                        rd_stb = ~byte_in[`RSD_SPI_WR_BIT];
                    end
                    next_st.addr = next_addr;
                    next_st.spi = RSD_SPI_DATA;
                    // Reads are fetched a byte early, so side effects land here
                    if (rd_stb) begin
                        next_st.sh_out = reg_read(st, next_addr, rx_enable, tx_enable);
                    end
                end
            end else if (fall && st.bitcnt != 3'h0) begin
                next_st.sh_out = {st.sh_out[6:0], 1'b0};
            end
        end

        // Read side effects: clears first so a same-cycle event still sets
        if (rd_stb && next_addr == `RSD_ADDR_RX_STAT) begin
            for (int c = 0; c < 2; c++) begin
                next_st.ch[c].eof = 1'b0;
                next_st.ch[c].flow = 1'b0;
                next_st.ch[c].full = 1'b0;
            end
        end
        if (rd_stb && next_addr == `RSD_ADDR_TX_STAT) begin
            next_st.tx_under = 1'b0;
            next_st.tx_over = 1'b0;
            next_st.tx_done = 1'b0;
        end
        for (int c = 0; c < 2; c++) begin
            if (rd_stb && next_addr == (c == 0 ? `RSD_ADDR_RX_BYTE_A : `RSD_ADDR_RX_BYTE_B)) begin
                if (st.ch[c].holding) begin
                    next_st.ch[c].holding = 1'b0;
                end else begin
                    next_st.ch[c].flow = 1'b1;
                end
            end
        end

        // Transmit serializer
        if (!tx_enable) begin
            next_st.sh_mask = 8'h00;
            next_st.tx_started = 1'b0;
            next_st.tx_bit_is_data = 1'b0;
        end else if (bit_tick) begin
            if (st.sh_mask != 8'h00) begin
                next_st.tx_bit = st.sh_data[0];
                next_st.tx_bit_is_data = st.sh_mask[0];
                next_st.sh_data = {1'b0, st.sh_data[7:1]};
                next_st.sh_mask = {1'b0, st.sh_mask[7:1]};
                next_st.tx_started = 1'b1;
                if (st.sh_mask[7:1] == 7'h00 && !st.tx_pend) begin
                    next_st.tx_done = 1'b1;
                end
            end else begin
                next_st.tx_bit = 1'b0;
                next_st.tx_bit_is_data = 1'b0;
                if (st.tx_started && !st.tx_pend) begin
                    next_st.tx_under = 1'b1;
                end
            end
        end else if (st.sh_mask == 8'h00 && st.tx_pend) begin
            move = 1'b1;
            next_st.sh_data = st.tx_byte;
            next_st.sh_mask = st.tx_mask;
            next_st.tx_pend = 1'b0;
        end

        // Register writes
        if (wr_stb) begin
            k = 3'(acc_addr - `RSD_ADDR_CODE_LO);
            case (acc_addr)
                `RSD_ADDR_TX_IRQ_EN: next_st.tx_irq_en = byte_in[3:0];
                `RSD_ADDR_TX_VALID: next_st.tx_mask = byte_in;
                `RSD_ADDR_TX_BYTE: begin
                    if (st.tx_pend && !move) begin
                        next_st.tx_over = 1'b1;
                    end
                    next_st.tx_byte = byte_in;
                    next_st.tx_pend = 1'b1;
                end
                `RSD_ADDR_ZERO_THR: next_st.thr = byte_in[6:0];
                default: begin
                    if (acc_addr >= `RSD_ADDR_CODE_LO && acc_addr <= `RSD_ADDR_CODE_HI) begin
                        next_st.code[{k, 3'b000} +: 8] = byte_in;
                    end
                end
            endcase
        end
        next_st.irq = tx_enable & (|(tx_flags(st) & st.tx_irq_en));

        // Receive deserializers
        for (int c = 0; c < 2; c++) begin
            next_st.ch[c].push = 1'b0;
            if (st.ch[c].push && !f_in_ready[c]) begin
                next_st.ch[c].flow = 1'b1;
            end
            if (f_out_valid[c] && !st.ch[c].holding) begin
                next_st.ch[c].byte_q = f_out_data[c][7:0];
                next_st.ch[c].valid_q = f_out_data[c][15:8];
                next_st.ch[c].holding = 1'b1;
                next_st.ch[c].full = 1'b1;
            end
            if (!rx_enable) begin
                next_st.ch[c].pos = 3'h0;
                next_st.ch[c].begun = 1'b0;
                next_st.ch[c].gap = 4'h0;
                next_st.ch[c].bits = 8'h00;
                next_st.ch[c].marks = 8'h00;
            end else if (bit_tick && (rx_bit_ok[c] || st.ch[c].begun)) begin
                nb = st.ch[c].bits;
                nm = st.ch[c].marks;
                nb[st.ch[c].pos] = rx_bit[c];
                nm[st.ch[c].pos] = rx_bit_ok[c];
                eof_hit = !rx_bit_ok[c] && st.ch[c].gap == {1'b0, eof_length};
                next_st.ch[c].begun = ~eof_hit;
                next_st.ch[c].gap = rx_bit_ok[c] ? 4'h0 : st.ch[c].gap + 4'h1;
                next_st.ch[c].bits = nb;
                next_st.ch[c].marks = nm;
                next_st.ch[c].pos = st.ch[c].pos + 3'h1;
                if (eof_hit) begin
                    next_st.ch[c].eof = 1'b1;
                    next_st.ch[c].gap = 4'h0;
                end
                if (eof_hit || st.ch[c].pos == 3'h7) begin
                    next_st.ch[c].push = 1'b1;
                    next_st.ch[c].push_word = {nm, nb};
                    next_st.ch[c].pos = 3'h0;
                    next_st.ch[c].bits = 8'h00;
                    next_st.ch[c].marks = 8'h00;
                end
            end
        end

        // Chip sequencer: full code or one 32-chip half
        if (chip_tick) begin
            last = code_short ? `RSD_CHIP_LAST_SHORT : `RSD_CHIP_LAST_LONG;
            next_st.chip = code_short ? st.code[{code_upper, st.chip_idx[4:0]}]
                                      : st.code[st.chip_idx];
            next_st.chip_idx = (st.chip_idx >= last) ? 6'h00 : st.chip_idx + 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
            st.sync1 <= 3'b001;
            st.sync2 <= 3'b001;
            st.spi <= RSD_SPI_IDLE;
            st.tx_irq_en <= 4'h0;
            st.code <= `RSD_RST_CODE;
            st.thr <= `RSD_RST_ZERO_THR;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign spi_miso = st.sh_out[7];
    assign spi_miso_oe = st.miso_oe;
    assign tx_bit = st.tx_bit;
    assign tx_bit_is_data = st.tx_bit_is_data;
    assign tx_irq_req = st.irq;
    assign chip = st.chip;
    assign spreading_code = st.code;
    assign zero_threshold = st.thr;
endmodule

// *** bench/rsd_serdes_regs_properties.sv ***
// Purpose: Port checks of the SERDES register block.
// Assumes: code_short and code_upper change only in reset.
// Notes: Chip index is mirrored from chip_tick.
`timescale 1ns/100ps
`include "rsd_regs.svh"
module rsd_regs_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic spi_miso_oe,
    input wire logic tx_enable,
    input wire logic bit_tick,
    input wire logic tx_bit,
    input wire logic tx_bit_is_data,
    input wire logic tx_irq_req,
    input wire logic chip_tick,
    input wire logic code_short,
    input wire logic code_upper,
    input wire logic chip,
    input wire logic [63:0] spreading_code,
    input wire logic [6:0] zero_threshold
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [5:0] idx_q;
    logic exp_chip;
    assign exp_chip = code_short ? spreading_code[{code_upper, idx_q[4:0]}] :
        spreading_code[idx_q];
    always_ff @(posedge clk) begin
        if (sys_rst)
            idx_q <= 6'h00;
        else if (chip_tick)
            idx_q <= (code_short ? idx_q[4:0] == 5'h1f : idx_q == 6'h3f) ? 6'h00 : idx_q + 6'h01;
    end
    irq_tx_off_a: assert property (!tx_enable |=> !tx_irq_req)
        else $error("irq with transmitter off");
    irq_after_rst_a: assert property ($fell(sys_rst) |-> !tx_irq_req [*8])
        else $error("irq without enable");
    code_reset_a: assert property ($fell(sys_rst) |-> spreading_code == `RSD_RST_CODE
        && zero_threshold == `RSD_RST_ZERO_THR) else $error("code reset value");
    chip_order_a: assert property (chip_tick |=> chip == $past(exp_chip))
        else $error("chip out of order");
    chip_hold_a: assert property (!chip_tick |=> $stable(chip))
        else $error("chip moved without tick");
    tx_hold_a: assert property (!bit_tick && tx_enable |=>
        $stable(tx_bit) && $stable(tx_bit_is_data)) else $error("tx moved without tick");
    data_cause_a: assert property ($rose(tx_bit_is_data) |->
        $past(bit_tick) && $past(tx_enable)) else $error("data bit without tick");
    quiet_rst_a: assert property ($fell(sys_rst) |-> !chip && !tx_bit_is_data
        && !spi_miso_oe) else $error("outputs busy after reset");
endmodule
bind rsd_serdes_regs rsd_regs_chk u_rsd_regs_chk (.clk, .sys_rst, .spi_miso_oe, .tx_enable,
    .bit_tick, .tx_bit, .tx_bit_is_data, .tx_irq_req, .chip_tick, .code_short, .code_upper,
    .chip, .spreading_code, .zero_threshold);

// *** bench/rsd_spi_host.sv ***
// Purpose: Host controller model on the serial register port.
// Assumes: Mode 0, 160 ns serial clock, one data byte per select.
// Notes: A released data line shows the inverse of its last value.
`timescale 1ns/100ps
module rsd_spi_host (
    output logic sclk,
    output logic mosi,
    output logic ss_n,
    input wire logic miso
);
    initial begin
        sclk = 1'b0;
        mosi = 1'b0;
        ss_n = 1'b1;
    end
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            #80;
            sclk = 1'b1;
            rx[i] = miso;
            #80;
            sclk = 1'b0;
        end
    endtask
    task automatic access(input logic wr, input logic [5:0] a, input logic [7:0] wd,
        output logic [7:0] rd);
        logic [7:0] junk;
        ss_n = 1'b0;
        #80;
        xfer({wr, 1'b0, a}, junk);
        xfer(wd, rd);
        #80;
        ss_n = 1'b1;
        mosi = ~mosi;
        #240;
    endtask
endmodule

// *** bench/test_radio_serdes_data_interface.sv ***
// Purpose: Self-checking bench of the SERDES register block.
// Assumes: Strobes change on the falling clock edge.
// Notes: Serial data line has a pull-up.
`timescale 1ns/100ps
`include "rsd_regs.svh"
module test_radio_serdes_data_interface;
    logic clk, sys_rst, rx_enable, tx_enable, bit_tick, chip_tick, code_short, code_upper;
    logic [2:0] eof_length;
    logic [1:0] rx_bit, rx_bit_ok;
    wire sclk, mosi, ss_n, miso, miso_oe, tx_bit, tx_bit_is_data, tx_irq_req, chip;
    wire miso_w = miso_oe ? miso : 1'b1;
    int num_errors = 0;
    int samples_checked = 0;
    rsd_spi_host u_rsd_spi_host (.sclk, .mosi, .ss_n, .miso(miso_w));
    rsd_serdes_regs u_rsd_serdes_regs (.clk, .sys_rst, .spi_sclk(sclk), .spi_mosi(mosi),
        .spi_ss_n(ss_n), .spi_miso(miso), .spi_miso_oe(miso_oe), .rx_enable, .tx_enable,
        .eof_length, .bit_tick, .rx_bit, .rx_bit_ok, .tx_bit, .tx_bit_is_data, .tx_irq_req,
        .chip_tick, .code_short, .code_upper, .chip, .spreading_code(), .zero_threshold());
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic tally_and_finish;
        if (num_errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t reg %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t pin %b exp %b", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        u_rsd_spi_host.access(1'b0, a, 8'h00, d);
    endtask
    task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk_reg(d, exp);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        logic [7:0] d;
        u_rsd_spi_host.access(1'b1, a, v, d);
    endtask
    task automatic tick(input logic [1:0] b, input logic [1:0] ok);
        @(negedge clk);
        rx_bit = b;
        rx_bit_ok = ok;
        bit_tick = 1'b1;
        @(negedge clk);
        bit_tick = 1'b0;
        @(negedge clk);
    endtask
    task automatic chips(input logic [7:0] exp);
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            chip_tick = 1'b1;
            @(negedge clk);
            chip_tick = 1'b0;
            chk_pin(chip, exp[i]);
        end
    endtask
    task automatic apply_reset;
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic sc_regs;
        rdc(`RSD_ADDR_TX_IRQ_EN, 8'h00);
        rdc(`RSD_ADDR_CODE_LO, 8'h22);
        rdc(6'h3f, 8'h00);
        wr(`RSD_ADDR_ZERO_THR, 8'hff);
        rdc(`RSD_ADDR_ZERO_THR, 8'h7f);
        wr(`RSD_ADDR_CODE_HI, 8'h5a);
        rdc(`RSD_ADDR_CODE_HI, 8'h5a);
    endtask
    task automatic sc_tx;
        logic [7:0] b = 8'ha5;
        @(negedge clk);
        tx_enable = 1'b1;
        tick(2'b00, 2'b00);
        rdc(`RSD_ADDR_TX_STAT, 8'h01);
        wr(`RSD_ADDR_TX_IRQ_EN, 8'h08);
        wr(`RSD_ADDR_TX_VALID, 8'h0f);
        wr(`RSD_ADDR_TX_BYTE, b);
        for (int i = 0; i < 5; i++) begin
            tick(2'b00, 2'b00);
            chk_pin(tx_bit_is_data, i < 4);
            if (i < 4)
                chk_pin(tx_bit, b[i]);
        end
        chk_pin(tx_irq_req, 1'b1);
        rdc(`RSD_ADDR_TX_STAT, 8'h0b);
        chk_pin(tx_irq_req, 1'b0);
        rdc(`RSD_ADDR_TX_STAT, 8'h01);
        wr(`RSD_ADDR_TX_VALID, 8'hff);
        repeat (3) wr(`RSD_ADDR_TX_BYTE, 8'h3c);
        rdc(`RSD_ADDR_TX_STAT, 8'h04);
        @(negedge clk);
        tx_enable = 1'b0;
        rdc(`RSD_ADDR_TX_STAT, 8'h00);
    endtask
    task automatic sc_rx_fifo;
        @(negedge clk);
        rx_enable = 1'b1;
        eof_length = 3'h7;
        for (int k = 1; k <= 34; k++)
            for (int i = 0; i < 8; i++)
                tick({1'b0, k[i]}, 2'b01);
        rdc(`RSD_ADDR_RX_STAT, 8'h0d);
        for (int k = 1; k <= 33; k++)
            rdc(`RSD_ADDR_RX_BYTE_A, 8'(k));
        rdc(`RSD_ADDR_RX_BYTE_A, 8'h21);
        rdc(`RSD_ADDR_RX_STAT, 8'h0d);
    endtask
    task automatic sc_rx_eof;
        logic [7:0] d;
        @(negedge clk);
        rx_enable = 1'b0;
        rdc(`RSD_ADDR_RX_STAT, 8'h00);
        @(negedge clk);
        rx_enable = 1'b1;
        eof_length = 3'h0;
        tick(2'b11, 2'b11);
        tick(2'b00, 2'b11);
        tick(2'b11, 2'b11);
        tick(2'b00, 2'b00);
        rdc(`RSD_ADDR_RX_STAT, 8'h33);
        rdc(`RSD_ADDR_RX_VALID_A, 8'h07);
        rdc(`RSD_ADDR_RX_VALID_B, 8'h07);
        rd(`RSD_ADDR_RX_BYTE_B, d);
        chk_reg(d & 8'h07, 8'h05);
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        {sys_rst, rx_enable, tx_enable, bit_tick, chip_tick, code_short, code_upper} = 7'h40;
        eof_length = 3'h0;
        rx_bit = 2'b00;
        rx_bit_ok = 2'b00;
        apply_reset;
        sc_regs;
        sc_tx;
        sc_rx_fifo;
        sc_rx_eof;
        chips(8'h22);
        code_short = 1'b1;
        code_upper = 1'b1;
        apply_reset;
        chips(8'h3d);
        tally_and_finish;
    end
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        tally_and_finish;
    end
endmodule
